/* common/lpms_pkg.sv */
// lpms_pkg: constants, register layouts and state types of the low power mode sequencer
// assumes a 32-bit apb slave port and a cpu core that honours the halt outputs
package lpms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_SYSTEM_CONTROL_ONE = 8'h38;
  localparam logic [7:0] IDX_SYSTEM_CONTROL_TWO = 8'h39;
  localparam logic [7:0] IDX_WAKEUP_KEY_CONTROL = 8'h3A;
  localparam logic [7:0] IDX_SEQ_STATUS         = 8'h3B;
  localparam int         ADDR_LSB               = 2;

  // reset values
  localparam logic [7:0] SC1_RESET = 8'h00;
  localparam logic [7:0] SC2_RESET = 8'h80;
  localparam logic [3:0] KEY_RESET = 4'h0;

  // program counter step past the mode start instruction
  localparam logic [15:0] PC_STEP = 16'h0002;

  // warm-up lengths in oscillator cycles, normal return then slow return
  localparam logic [17:0] WARM_FAST_00 = 18'h30000;
  localparam logic [17:0] WARM_FAST_01 = 18'h10000;
  localparam logic [17:0] WARM_FAST_10 = 18'h0C000;
  localparam logic [17:0] WARM_FAST_11 = 18'h04000;
  localparam logic [17:0] WARM_SLOW_00 = 18'h06000;
  localparam logic [17:0] WARM_SLOW_01 = 18'h02000;
  localparam logic [17:0] WARM_SLOW_10 = 18'h000C0;
  localparam logic [17:0] WARM_SLOW_11 = 18'h00040;
  localparam int          WARM_W       = 18;

  ////////////////////////////////////////////////////////////////////////////
  // system_control_one layout, bits 1:0 read as zero
  typedef struct packed {
    logic       start;
    logic       release_method_select;
    logic       return_mode_select;
    logic       halt_port_output_keep;
    logic [1:0] warmup_length_field;
    logic [1:0] rsvd;
  } lpms_sc1_t;

  // system_control_two layout, bits 3, 1 and 0 read as zero
  typedef struct packed {
    logic       hf_osc_on;
    logic       lf_osc_on;
    logic       slow_clock_sel;
    logic       core_halt;
    logic       rsvd3;
    logic       timing_gen_feed_halt;
    logic [1:0] rsvd;
  } lpms_sc2_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_RUN       = 2'b00,
    ST_FULL_HALT = 2'b01,
    ST_WARMUP    = 2'b10,
    ST_CORE_HALT = 2'b11
  } lpms_state_t;

  // all state of the top module
  typedef struct packed {
    lpms_state_t st;
    lpms_sc1_t   sc1;
    lpms_sc2_t   sc2;
    logic [3:0]  key_en;
    logic        release_method_select_eff;
    logic        pin_d;
    logic [3:0]  key_d;
    logic [15:0] resume_pc;
    logic        resume;
    logic        irq_svc;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        halt_cpu;
    logic        halt_periph;
    logic        osc_hf;
    logic        osc_lf;
    logic        presc_clr;
    logic        port_hiz;
  } lpms_regs_t;

endpackage : lpms_pkg

/* logic/lpms_warmup_cnt.sv */
// lpms_warmup_cnt: warm-up counter that counts oscillator ticks up to a terminal count
// assumes tick is a one-cycle pulse per oscillator cycle, synchronous to pclk
`timescale 1ns/1ps
module lpms_warmup_cnt
  import lpms_pkg::*;
#(
  parameter int W = WARM_W
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] terminal,
  // result
  output logic              done
);

  initial begin
    if (W < 2) $error("lpms_warmup_cnt: W too small");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // count from zero while running, done on the tick that reaches terminal
  always_comb begin
    done    = run & tick & (cnt_r == terminal - W'(1));
    cnt_nxt = cnt_r;
    if (!run || done) begin
      cnt_nxt = '0;
    end else if (tick) begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : lpms_warmup_cnt

/* logic/lpms_top.sv */
// lpms_top: full-halt and core-halt sequencer with warm-up timing and an apb register port
// assumes all pins are synchronous to pclk, presetn is the device reset pin,
// and hf_tick / lf_tick pulse once per high / low frequency oscillator cycle
`timescale 1ns/1ps

// Summary of operation
// - start bit write enters full halt
// - memory and registers held during full halt
// - prescaler and divider cleared in full halt
// - resume address is start address plus two
// - method bit: one level, zero edge
// - level mode: pin high or key edge
// - level mode, pin high: straight to warm-up
// - no return to halt once warming
// - edge to level switch waits pin rise
// - edge mode halts always, rise releases
// - oscillators restarted by return mode
// - warm-up holds everything, four lengths
// - warm-up counts oscillator cycles
// - reset pin ends full halt at once
// - core halt stops cpu and watchdog only
// - core-halt bit write enters core halt
// - core halt release clears bit, returns
// - master flag zero: wake, no service
// - master flag one: wake and service
// - reset pin ends core halt, normal
// - watchdog irq cancels core halt entry
// - warm-up code table fast and slow
// - return mode selects normal or slow
// - keep bit chooses port drive or float
module lpms_top
  import lpms_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int WARM_SHIFT = 0
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // wake pins and oscillator ticks
  input  wire logic              port2_bit0,
  input  wire logic [3:0]        key_wakeup_inputs,
  input  wire logic              hf_tick,
  input  wire logic              lf_tick,
  // cpu core side
  input  wire logic [15:0]       start_insn_addr,
  input  wire logic              master_irq_flag,
  input  wire logic              irq_wake_req,
  input  wire logic              watchdog_irq,
  // halt and clock controls
  output logic                   cpu_halt,
  output logic                   wdt_halt,
  output logic                   periph_halt,
  output logic                   hf_osc_en,
  output logic                   lf_osc_en,
  output logic                   main_clk_slow,
  output logic                   prescaler_clear,
  output logic                   port_out_hiz,
  output logic [15:0]            resume_pc,
  output logic                   resume_pulse,
  output logic                   irq_service
);

  initial begin
    if (ADDR_W < 10 || ADDR_W > 32) $error("lpms_top: ADDR_W out of range");
    if (WARM_SHIFT < 0 || WARM_SHIFT > 6) $error("lpms_top: WARM_SHIFT out of range");
  end

  lpms_regs_t        r;
  lpms_regs_t        n;
  logic              wu_done;
  logic [WARM_W-1:0] wu_term;
  logic              wu_tick;

  ////////////////////////////////////////////////////////////////////////////
  // warm-up length lookup, shortened by WARM_SHIFT only for simulation
  function automatic logic [WARM_W-1:0] warm_len(input logic [1:0] code, input logic slow);
    logic [WARM_W-1:0] v;
    v = '0;
    unique case ({slow, code})
      3'b000: v = WARM_FAST_00;
      3'b001: v = WARM_FAST_01;
      3'b010: v = WARM_FAST_10;
      3'b011: v = WARM_FAST_11;
      3'b100: v = WARM_SLOW_00;
      3'b101: v = WARM_SLOW_01;
      3'b110: v = WARM_SLOW_10;
      3'b111: v = WARM_SLOW_11;
    endcase
    v = v >> WARM_SHIFT;
    if (v == '0) v = WARM_W'(1);
    return v;
  endfunction : warm_len

  // slow return counts low-frequency cycles, normal return high-frequency ones
  assign wu_tick = r.sc1.return_mode_select ? lf_tick : hf_tick;
  assign wu_term = warm_len(r.sc1.warmup_length_field, r.sc1.return_mode_select);

  lpms_warmup_cnt #(
    .W (WARM_W)
  ) u_warm (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (r.st == ST_WARMUP),
    .tick     (wu_tick),
    .terminal (wu_term),
    .done     (wu_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for registers, sequencer and outputs
  always_comb begin
    logic              setup;
    logic              acc_wr;
    logic              aligned;
    logic [7:0]        idx;
    logic              pin_rise;
    logic              key_hit;
    logic              start_full;
    logic              start_core;
    logic              hit;
    lpms_sc1_t         w1;
    lpms_sc2_t         w2;
    setup      = 1'b0;
    acc_wr     = 1'b0;
    aligned    = 1'b0;
    idx        = 8'h00;
    pin_rise   = 1'b0;
    key_hit    = 1'b0;
    start_full = 1'b0;
    start_core = 1'b0;
    hit        = 1'b0;
    w1         = lpms_sc1_t'(pwdata[7:0]);
    w2         = lpms_sc2_t'(pwdata[7:0]);
    n          = r;
    n.resume   = 1'b0;
    n.irq_svc  = 1'b0;
    n.pready   = 1'b0;
    n.pin_d    = port2_bit0;
    n.key_d    = key_wakeup_inputs;

    // pin events, sampled against the previous cycle
    pin_rise = port2_bit0 & ~r.pin_d;
    key_hit  = |((key_wakeup_inputs ^ r.key_d) & r.key_en);

    // apb decode: answer one cycle after setup, errors for unmapped words
    setup   = psel & ~penable;
    acc_wr  = psel & penable & pwrite & r.pready & ~r.pslverr;
    aligned = (paddr[ADDR_LSB-1:0] == '0) &&
              (paddr[ADDR_W-1:ADDR_LSB] >> 8 == '0);
    idx     = paddr[ADDR_LSB+7:ADDR_LSB];
    if (setup) begin
      n.pready  = 1'b1;
      n.prdata  = 32'h0000_0000;
      hit       = 1'b1;
      unique case (idx)
        IDX_SYSTEM_CONTROL_ONE: n.prdata[7:0] = {r.sc1[7:2], 2'b00};
        IDX_SYSTEM_CONTROL_TWO: n.prdata[7:0] = {r.sc2[7:4], 1'b0, r.sc2[2], 2'b00};
        IDX_WAKEUP_KEY_CONTROL: n.prdata[3:0] = r.key_en;
        IDX_SEQ_STATUS:         n.prdata[4:0] = {r.pin_d, r.release_method_select_eff, 1'b0, r.st};
        default:                hit = 1'b0;
      endcase
      n.pslverr = ~(hit & aligned);
      if (n.pslverr || pwrite) n.prdata = 32'h0000_0000;
    end else begin
      n.pslverr = 1'b0;
    end

    // register writes take effect at the access edge
    if (acc_wr) begin
      unique case (idx)
        IDX_SYSTEM_CONTROL_ONE: begin
          n.sc1.release_method_select = w1.release_method_select;
          n.sc1.return_mode_select    = w1.return_mode_select;
          n.sc1.halt_port_output_keep = w1.halt_port_output_keep;
          n.sc1.warmup_length_field   = w1.warmup_length_field;
          // edge mode takes over at once, level mode waits for a pin rise
          if (!w1.release_method_select) n.release_method_select_eff = 1'b0;
          start_full = w1.start & (r.st == ST_RUN);
        end
        IDX_SYSTEM_CONTROL_TWO: begin
          n.sc2.hf_osc_on            = w2.hf_osc_on;
          n.sc2.lf_osc_on            = w2.lf_osc_on;
          n.sc2.slow_clock_sel       = w2.slow_clock_sel;
          n.sc2.timing_gen_feed_halt = w2.timing_gen_feed_halt;
          start_core = w2.core_halt & (r.st == ST_RUN);
        end
        IDX_WAKEUP_KEY_CONTROL: n.key_en = pwdata[3:0];
        default: ;
      endcase
    end

    // a pending level selection becomes live on the first pin rise
    if (pin_rise && n.sc1.release_method_select) begin
      n.release_method_select_eff = 1'b1;
    end

    // sequencer; the old method stays in force for this cycle's release
    unique case (r.st)
      ST_RUN: begin
        if (start_full) begin
          n.sc1.start  = 1'b1;
          n.resume_pc  = start_insn_addr + PC_STEP;
          if (r.release_method_select_eff && port2_bit0) begin
            n.st = ST_WARMUP;
          end else begin
            n.st = ST_FULL_HALT;
          end
        end else if (start_core) begin
          if (watchdog_irq) begin
            n.irq_svc = 1'b1;
          end else begin
            n.sc2.core_halt = 1'b1;
            n.resume_pc     = start_insn_addr + PC_STEP;
            n.st            = ST_CORE_HALT;
          end
        end
      end
      ST_FULL_HALT: begin
        // key inputs are honoured only in level mode
        if (r.release_method_select_eff ? (port2_bit0 | key_hit) : pin_rise) begin
          n.st = ST_WARMUP;
        end
      end
      ST_WARMUP: begin
        // pin level is ignored here: once warming the halt is never re-entered
        if (wu_done) begin
          n.st        = ST_RUN;
          n.sc1.start = 1'b0;
          n.resume    = 1'b1;
          if (r.sc1.return_mode_select) begin
            n.sc2.slow_clock_sel = 1'b1;
            n.sc2.lf_osc_on      = 1'b1;
            n.sc2.hf_osc_on      = 1'b0;
          end else begin
            n.sc2.slow_clock_sel = 1'b0;
            n.sc2.hf_osc_on      = 1'b1;
          end
        end
      end
      ST_CORE_HALT: begin
        if (irq_wake_req) begin
          n.st            = ST_RUN;
          n.sc2.core_halt = 1'b0;
          n.resume        = 1'b1;
          n.irq_svc       = master_irq_flag;
        end
      end
    endcase

    // registered controls follow the next state
    n.halt_cpu    = (n.st != ST_RUN);
    n.halt_periph = (n.st == ST_FULL_HALT) || (n.st == ST_WARMUP);
    n.presc_clr   = n.halt_periph;
    n.port_hiz    = (n.st == ST_FULL_HALT) & ~n.sc1.halt_port_output_keep;
    unique case (n.st)
      ST_FULL_HALT: begin
        n.osc_hf = 1'b0;
        n.osc_lf = 1'b0;
      end
      ST_WARMUP: begin
        // dual clock to normal restarts both, slow restarts low only
        n.osc_hf = ~n.sc1.return_mode_select;
        n.osc_lf = n.sc1.return_mode_select | n.sc2.lf_osc_on;
      end
      default: begin
        n.osc_hf = n.sc2.hf_osc_on;
        n.osc_lf = n.sc2.lf_osc_on;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; the reset pin ends every halt into single-clock normal run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.st          <= ST_RUN;
      r.sc1         <= lpms_sc1_t'(SC1_RESET);
      r.sc2         <= lpms_sc2_t'(SC2_RESET);
      r.key_en      <= KEY_RESET;
      r.release_method_select_eff    <= 1'b0;
      r.pin_d       <= 1'b0;
      r.key_d       <= 4'h0;
      r.resume_pc   <= 16'h0000;
      r.resume      <= 1'b0;
      r.irq_svc     <= 1'b0;
      r.prdata      <= 32'h0000_0000;
      r.pready      <= 1'b0;
      r.pslverr     <= 1'b0;
      r.halt_cpu    <= 1'b0;
      r.halt_periph <= 1'b0;
      r.osc_hf      <= 1'b1;
      r.osc_lf      <= 1'b0;
      r.presc_clr   <= 1'b0;
      r.port_hiz    <= 1'b0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign prdata          = r.prdata;
  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign cpu_halt        = r.halt_cpu;
  assign wdt_halt        = r.halt_cpu;
  assign periph_halt     = r.halt_periph;
  assign hf_osc_en       = r.osc_hf;
  assign lf_osc_en       = r.osc_lf;
  assign main_clk_slow   = r.sc2.slow_clock_sel;
  assign prescaler_clear = r.presc_clr;
  assign port_out_hiz    = r.port_hiz;
  assign resume_pc       = r.resume_pc;
  assign resume_pulse    = r.resume;
  assign irq_service     = r.irq_svc;

endmodule : lpms_top

/* verif/lpms_top_sva.sv */
// lpms_top_sva: concurrent checks on the sequencer ports
// assumes it is bound into every lpms_top and sees only that module's ports
`timescale 1ns/1ps
module lpms_top_sva
  import lpms_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb request side
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  // cpu core side
  input wire logic [15:0]       start_insn_addr,
  input wire logic              master_irq_flag,
  input wire logic              irq_wake_req,
  input wire logic              watchdog_irq,
  // halt and clock controls
  input wire logic              cpu_halt,
  input wire logic              wdt_halt,
  input wire logic              periph_halt,
  input wire logic              hf_osc_en,
  input wire logic              lf_osc_en,
  input wire logic              prescaler_clear,
  input wire logic              port_out_hiz,
  input wire logic [15:0]       resume_pc,
  input wire logic              resume_pulse,
  input wire logic              irq_service
);
  localparam logic [ADDR_W-1:0] A_SC1 = ADDR_W'({IDX_SYSTEM_CONTROL_ONE, 2'b00});
  localparam logic [ADDR_W-1:0] A_SC2 = ADDR_W'({IDX_SYSTEM_CONTROL_TWO, 2'b00});

  // a write commits only at the edge where pready is seen high
  wire wr_c = psel && penable && pready && pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // full halt
  chk_halt_entry: assert property (wr_c && paddr == A_SC1 && pwdata[7] && !cpu_halt
    |=> cpu_halt && periph_halt) else $error("halt not entered after start write");
  chk_presc_clear: assert property (prescaler_clear == periph_halt)
    else $error("prescaler clear differs from halt");
  chk_pc_step: assert property ($rose(cpu_halt) |-> resume_pc == $past(start_insn_addr) + PC_STEP)
    else $error("resume address not start plus two");
  chk_hiz_only_halt: assert property (port_out_hiz |-> periph_halt && !hf_osc_en && !lf_osc_en)
    else $error("port float outside full halt");
  // warm-up may only end in run, never fall back to a stopped oscillator
  chk_warm_no_back: assert property (periph_halt && (hf_osc_en || lf_osc_en)
    |=> !periph_halt || hf_osc_en || lf_osc_en) else $error("warm-up fell back to halt");

  ////////////////////////////////////////////////////////////////////////////
  // core halt
  chk_cpu_wdt_pair: assert property (cpu_halt == wdt_halt)
    else $error("cpu and watchdog halt differ");
  chk_core_wake: assert property (cpu_halt && !periph_halt && irq_wake_req
    |=> resume_pulse && !cpu_halt && irq_service == $past(master_irq_flag)) else $error("core wake wrong");
  chk_wdt_cancel: assert property (wr_c && paddr == A_SC2 && pwdata[4] && watchdog_irq && !cpu_halt
    |=> irq_service && !cpu_halt) else $error("watchdog did not cancel core halt");
  chk_resume_once: assert property (resume_pulse |=> !resume_pulse && !cpu_halt)
    else $error("resume pulse too long");

  // main scenarios reached
  cov_irq_wake: cover property (resume_pulse && irq_service);
  cov_float: cover property ($rose(port_out_hiz));
  cov_slow_warm: cover property (periph_halt && lf_osc_en && !hf_osc_en);
endmodule : lpms_top_sva

bind lpms_top lpms_top_sva #(.ADDR_W(ADDR_W)) u_sva (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
  .start_insn_addr, .master_irq_flag, .irq_wake_req, .watchdog_irq,
  .cpu_halt, .wdt_halt, .periph_halt, .hf_osc_en, .lf_osc_en, .prescaler_clear,
  .port_out_hiz, .resume_pc, .resume_pulse, .irq_service
);

/* verif/lpms_wake_model.sv */
// lpms_wake_model: release pin, key pins and oscillator ticks around the sequencer
// assumes the bench sets the wanted pin levels through pin_req and key_req
`timescale 1ns/1ps
module lpms_wake_model
  import lpms_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // requests from the bench
  input  wire logic       pin_req,
  input  wire logic [3:0] key_req,
  // oscillator enables
  input  wire logic       hf_osc_en,
  input  wire logic       lf_osc_en,
  // toward the sequencer
  output logic            port2_bit0,
  output logic [3:0]      key_wakeup_inputs,
  output logic            hf_tick,
  output logic            lf_tick
);
  logic [2:0] div_r;

  // a stopped oscillator gives no ticks; hf every 2nd cycle, lf every 8th
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r   <= 3'h0;
      hf_tick <= 1'b0;
      lf_tick <= 1'b0;
    end else begin
      div_r   <= div_r + 3'h1;
      hf_tick <= hf_osc_en && div_r[0];
      lf_tick <= lf_osc_en && (div_r == 3'h7);
    end
  end

  // pins are outside the device, so the device reset leaves them alone
  always_ff @(posedge pclk) begin
    port2_bit0        <= pin_req;
    key_wakeup_inputs <= key_req;
  end
endmodule : lpms_wake_model

/* verif/lpms_top_tb_top.sv */
// lpms_top_tb_top: self-checking bench for the low power mode sequencer
// assumes lpms_top, lpms_wake_model and the bound checker are compiled before it
`timescale 1ns/1ps
// compare two values, count it, report a mismatch at once
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module lpms_top_tb_top
  import lpms_pkg::*;
  ;
  localparam int SH = 6;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, port2_bit0, hf_tick, lf_tick, pin_req = 1'b0;
  logic        master_irq_flag = 1'b0, irq_wake_req = 1'b0, watchdog_irq = 1'b0;
  logic        cpu_halt, wdt_halt, periph_halt, hf_osc_en, lf_osc_en, main_clk_slow;
  logic        prescaler_clear, port_out_hiz, resume_pulse, irq_service;
  logic [3:0]  key_req = 4'h0, key_wakeup_inputs;
  logic [15:0] start_insn_addr = 16'h1234, resume_pc;
  int          mismatches = 0, compares = 0, hf_n = 0, lf_n = 0;

  lpms_top #(.ADDR_W(12), .WARM_SHIFT(SH)) dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .port2_bit0, .key_wakeup_inputs, .hf_tick, .lf_tick, .start_insn_addr, .master_irq_flag,
    .irq_wake_req, .watchdog_irq, .cpu_halt, .wdt_halt, .periph_halt, .hf_osc_en, .lf_osc_en,
    .main_clk_slow, .prescaler_clear, .port_out_hiz, .resume_pc, .resume_pulse, .irq_service);
  lpms_wake_model u_wake (
    .pclk, .presetn, .pin_req, .key_req, .hf_osc_en, .lf_osc_en,
    .port2_bit0, .key_wakeup_inputs, .hf_tick, .lf_tick);

  initial begin
    forever #10 pclk = ~pclk;
  end

  // warm-up ticks seen while everything is held, sampled mid-cycle where settled
  always @(negedge pclk) begin
    if (hf_tick === 1'b1 && periph_halt === 1'b1) hf_n++;
    if (lf_tick === 1'b1 && periph_halt === 1'b1) lf_n++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look at pready where it is settled, ahead of the edge that samples it
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) mismatches++;
  endtask : apb

  task automatic wait_resume();
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (resume_pulse !== 1'b1 && n < 8000);
    `CHK(resume_pulse, 1'b1)
  endtask : wait_resume

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(0, IDX_SYSTEM_CONTROL_ONE, 0); `CHK(q, {24'h0, SC1_RESET})
    apb(0, IDX_SYSTEM_CONTROL_TWO, 0); `CHK(q, {24'h0, SC2_RESET})
    apb(0, IDX_SEQ_STATUS, 0); `CHK(q[3:0], 4'h0)
    apb(0, 8'h3C, 0); `CHK({e, q}, {1'b1, 32'h0})
    apb(1, IDX_SYSTEM_CONTROL_ONE, 32'h1F);
    apb(0, IDX_SYSTEM_CONTROL_ONE, 0); `CHK(q, 32'h1C)
    apb(1, IDX_WAKEUP_KEY_CONTROL, 32'h2);
    apb(0, IDX_WAKEUP_KEY_CONTROL, 0); `CHK(q[3:0], 4'h2)
    $display("t_regs done");
  endtask : t_regs

  // edge release, pin already high at start, fast return
  task automatic t_edge();
    master_irq_flag <= 1'b0;
    pin_req <= 1'b1;
    apb(1, IDX_SYSTEM_CONTROL_ONE, 32'h8C);
    @(negedge pclk);
    `CHK({cpu_halt, periph_halt, prescaler_clear, port_out_hiz, hf_osc_en, lf_osc_en}, 6'h3C)
    `CHK(resume_pc, start_insn_addr + PC_STEP)
    // cleared on a rising edge so it never meets the tick counter's edge
    repeat (5) @(posedge pclk);
    hf_n = 0;
    apb(0, IDX_SEQ_STATUS, 0); `CHK(q[1:0], 2'h1)
    apb(0, IDX_SYSTEM_CONTROL_TWO, 0); `CHK(q[7:0], SC2_RESET)
    pin_req <= 1'b0;
    repeat (4) @(posedge pclk);
    pin_req <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK({periph_halt, hf_osc_en}, 2'b11)
    wait_resume();
    `CHK({cpu_halt, hf_osc_en}, 2'b01)
    `CHK(hf_n, int'(WARM_FAST_11 >> SH))
    apb(0, IDX_SYSTEM_CONTROL_ONE, 0); `CHK(q[7:0], 8'h0C)
    $display("t_edge done");
  endtask : t_edge

  // level release: method switch, skipped halt, key wake to slow
  task automatic t_level();
    pin_req <= 1'b0;
    apb(1, IDX_SYSTEM_CONTROL_ONE, 32'h40);
    apb(0, IDX_SEQ_STATUS, 0); `CHK(q[3], 1'b0)
    pin_req <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, IDX_SEQ_STATUS, 0); `CHK(q[3], 1'b1)
    apb(1, IDX_SYSTEM_CONTROL_ONE, 32'hC0);
    pin_req <= 1'b0;
    apb(0, IDX_SEQ_STATUS, 0); `CHK(q[1:0], 2'h2)
    repeat (8) @(posedge pclk);
    apb(0, IDX_SEQ_STATUS, 0); `CHK(q[1:0], 2'h2)
    wait_resume();
    apb(1, IDX_SYSTEM_CONTROL_ONE, 32'hEC);
    lf_n = 0;
    apb(0, IDX_SEQ_STATUS, 0); `CHK(q[1:0], 2'h1)
    key_req <= 4'h2;
    wait_resume();
    `CHK(lf_n, int'(WARM_SLOW_11 >> SH))
    `CHK({hf_osc_en, lf_osc_en, main_clk_slow}, 3'b011)
    @(posedge pclk);
    key_req <= 4'h0;
    $display("t_level done");
  endtask : t_level

  // core halt with both master flag values, then a watchdog cancel
  task automatic t_core();
    for (int f = 0; f < 2; f++) begin
      master_irq_flag <= f[0];
      apb(1, IDX_SYSTEM_CONTROL_TWO, 32'h70);
      @(posedge pclk);
      `CHK({cpu_halt, wdt_halt, periph_halt}, 3'b110)
      irq_wake_req <= 1'b1;
      wait_resume();
      `CHK({irq_service, cpu_halt}, {f[0], 1'b0})
      @(posedge pclk);
      irq_wake_req <= 1'b0;
      apb(0, IDX_SYSTEM_CONTROL_TWO, 0); `CHK(q[7:4], 4'h6)
    end
    watchdog_irq <= 1'b1;
    apb(1, IDX_SYSTEM_CONTROL_TWO, 32'h70);
    watchdog_irq <= 1'b0;
    @(negedge pclk);
    `CHK({irq_service, cpu_halt}, 2'b10)
    $display("t_core done");
  endtask : t_core

  // reset pin in mid halt, ports kept driven
  task automatic t_reset();
    apb(1, IDX_SYSTEM_CONTROL_ONE, 32'hB0);
    @(posedge pclk);
    `CHK({cpu_halt, port_out_hiz}, 2'b10)
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK({cpu_halt, hf_osc_en, main_clk_slow}, 3'b010)
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_SYSTEM_CONTROL_TWO, 0); `CHK(q[7:0], SC2_RESET)
    $display("t_reset done");
  endtask : t_reset

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_edge();
    t_level();
    t_core();
    t_reset();
    test_done();
  end

  // the longest warm-up here is some 6200 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    test_done();
  end
endmodule : lpms_top_tb_top
